/* design/irq_flag_pkg.sv */
// Purpose: shared constants, types and helpers of the interrupt flag block
// Assumes: 32-bit AXI4-Lite register port with a 16-bit byte address
// Notes: flag bit positions follow the interrupt flag register layout

package irq_flag_pkg;

	// ****************************************
	// bus geometry and responses
	// ****************************************
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [15:0] OFF_CLEAR = 16'h3004;
	localparam logic [15:0] OFF_SELECT_0 = 16'h3008;
	localparam logic [15:0] OFF_SELECT_1 = 16'h300c;
	localparam logic [15:0] OFF_FLAGS_0 = 16'h3010;
	localparam logic [15:0] OFF_FLAGS_1 = 16'h3014;
	localparam logic [15:0] OFF_EVENT_STATUS = 16'h3018;
	localparam logic [15:0] OFF_EVENT_MASK = 16'h301c;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] RST_FLAGS = 32'h00000000;
	localparam logic [31:0] RST_SELECT = 32'h00002000;
	localparam logic [31:0] RST_EVENT_STATUS = 32'h00000000;
	localparam logic [31:0] RST_EVENT_MASK = 32'h00000000;
	localparam logic [31:0] ALL_ONES = 32'hffffffff;
	localparam logic [31:0] ALL_ZEROS = 32'h00000000;

	// ****************************************
	// flag bit positions
	// ****************************************
	localparam int unsigned BIT_BREAK = 31;
	localparam int unsigned BIT_OUTLIER = 29;
	localparam int unsigned BIT_FIFO_UNDERFLOW = 27;
	localparam int unsigned BIT_FIFO_OVERFLOW = 26;
	localparam int unsigned BIT_FIFO_THRESHOLD = 25;
	localparam int unsigned BIT_FIFO_EMPTY = 24;
	localparam int unsigned BIT_FIFO_FULL = 23;
	localparam int unsigned BIT_SEQ_TIMEOUT_ERROR = 17;
	localparam int unsigned BIT_SEQ_TIMEOUT_DONE = 16;
	localparam int unsigned BIT_END_OF_SEQUENCE = 15;
	localparam int unsigned BIT_BOOT_DONE = 13;
	// implemented flag bits; all others read as zero
	localparam logic [31:0] IMPL_MASK = 32'haf83a000;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] waddr;
		logic [15:0] raddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
	} reg_req_s;

	typedef enum logic [2:0] {
		seq_idle = 3'b001,
		seq_run_a = 3'b010,
		seq_run_b = 3'b100
	} seq_state_e;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic addr_hit(input logic [15:0] addr,
		input logic [15:0] off);
		addr_hit = (addr[15:2] == off[15:2]);
	endfunction : addr_hit

	function automatic logic is_mapped(input logic [15:0] addr);
		is_mapped = addr_hit(addr, OFF_CLEAR) | addr_hit(addr, OFF_SELECT_0) |
			addr_hit(addr, OFF_SELECT_1) | addr_hit(addr, OFF_FLAGS_0) |
			addr_hit(addr, OFF_FLAGS_1) | addr_hit(addr, OFF_EVENT_STATUS) |
			addr_hit(addr, OFF_EVENT_MASK);
	endfunction : is_mapped

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : strb_mask

endpackage : irq_flag_pkg

/* design/sticky_bank.sv */
// Purpose: 32 sticky bits, set by events and cleared by a vector
// Assumes: set and clear come from logic on clk_sys
// Notes: a set in the clearing cycle wins

`timescale 1ns/1ps
`default_nettype none

module sticky_bank (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [31:0] set,
	input wire logic [31:0] clr,
	output logic [31:0] q
);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q <= irq_flag_pkg::RST_FLAGS;
		end else begin
			q <= (q & ~clr) | set;
		end
	end

endmodule : sticky_bank

`default_nettype wire

/* design/axil_reg_port.sv */
// Purpose: AXI4-Lite slave front turning bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes: write strobe one cycle after both address and data are accepted

`timescale 1ns/1ps
`default_nettype none

module axil_reg_port (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output irq_flag_pkg::reg_req_s req,
	input wire logic [31:0] rd_data,
	input wire logic rd_err,
	input wire logic wr_err
);

	logic aw_held;
	logic w_held;
	logic ar_held;
	logic wr_go;
	logic rd_go;
	logic [15:0] waddr;
	logic [15:0] raddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !ar_held && !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign rd_go = ar_held && !s_axi_rvalid;
	// one driver for the whole request bundle
	assign req = '{wr: wr_go, rd: rd_go, waddr: waddr, raddr: raddr,
		wdata: wdata, wstrb: wstrb};

	// ****************************************
	// write path
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			waddr <= 16'h0000;
			wdata <= 32'h00000000;
			wstrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				waddr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata <= s_axi_wdata;
				wstrb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= irq_flag_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_err ? irq_flag_pkg::RESP_SLVERR :
				irq_flag_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ar_held <= 1'b0;
			raddr <= 16'h0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_held <= 1'b1;
			raddr <= s_axi_araddr;
		end else if (rd_go) begin
			ar_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= irq_flag_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? irq_flag_pkg::RESP_SLVERR :
				irq_flag_pkg::RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : axil_reg_port

`default_nettype wire

/* design/interrupt_flag_status.sv */
// Purpose: interrupt flag registers, enables, clear and sequence arbiter
// Assumes: event inputs are one-cycle pulses or levels on clk_sys
// Notes: flags are sticky; events also feed a read-to-clear summary
//
// Overview of operation
// - two read-only flag words, zero after reset
// - bit 31 flags second-sequence request during first
// - second-sequence request while first runs is dropped
// - bit 27 reports fifo underflow
// - bit 26 reports fifo overflow
// - bit 25 reports fifo threshold
// - bit 24 reports fifo empty
// - bit 23 reports fifo full
// - bit 17 reports sequencer timeout error
// - bit 16 reports sequencer timeout finished
// - bit 15 reports end of sequence
// - bit 13 reports boot load done
// - writing one to clear bit drops flag
// - select bits enable sources, boot done enabled
//
// Implementation choice: register access over AXI4-Lite.

`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_status (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic seq_a_req,
	input wire logic seq_b_req,
	input wire logic seq_done,
	output logic seq_a_start,
	output logic seq_b_start,
	output logic seq_a_busy,
	output logic seq_b_busy,
	input wire logic outlier_event,
	input wire logic fifo_underflow_event,
	input wire logic fifo_overflow_event,
	input wire logic fifo_threshold_event,
	input wire logic fifo_empty_event,
	input wire logic fifo_full_event,
	input wire logic seq_timeout_error_event,
	input wire logic seq_timeout_done_event,
	input wire logic boot_done_event,
	output logic irq
);

	irq_flag_pkg::reg_req_s req;
	irq_flag_pkg::seq_state_e seq_state;
	irq_flag_pkg::seq_state_e next_seq_state;
	logic [31:0] interrupt_flags_0;
	logic [31:0] interrupt_flags_1;
	logic [31:0] irq_enable_0;
	logic [31:0] irq_enable_1;
	logic [31:0] event_status;
	logic [31:0] event_mask;
	logic [31:0] events;
	logic [31:0] irq_clear_bit;
	logic [31:0] status_clear;
	logic [31:0] rd_data;
	logic [31:0] wmask;
	logic rd_err;
	logic wr_err;
	logic break_attempt;
	logic end_of_sequence;

	// ****************************************
	// bus front
	// ****************************************
	axil_reg_port u_port (
		.clk_sys(clk_sys),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.req(req),
		.rd_data(rd_data),
		.rd_err(rd_err),
		.wr_err(wr_err)
	);

	assign wmask = irq_flag_pkg::strb_mask(req.wstrb);
	assign rd_err = !irq_flag_pkg::is_mapped(req.raddr);
	assign wr_err = !irq_flag_pkg::is_mapped(req.waddr);

	// ****************************************
	// sequence arbiter
	// ****************************************
	always_comb begin
		next_seq_state = seq_state;
		case (seq_state)
			irq_flag_pkg::seq_idle: begin
				if (seq_a_req) begin
					next_seq_state = irq_flag_pkg::seq_run_a;
				end else if (seq_b_req) begin
					next_seq_state = irq_flag_pkg::seq_run_b;
				end
			end
			irq_flag_pkg::seq_run_a: begin
				if (seq_done) begin
					next_seq_state = irq_flag_pkg::seq_idle;
				end
			end
			irq_flag_pkg::seq_run_b: begin
				if (seq_done) begin
					next_seq_state = irq_flag_pkg::seq_idle;
				end
			end
			default: begin
				next_seq_state = irq_flag_pkg::seq_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seq_state <= irq_flag_pkg::seq_idle;
		end else begin
			seq_state <= next_seq_state;
		end
	end

	// one-cycle start pulses toward the sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seq_a_start <= 1'b0;
			seq_b_start <= 1'b0;
		end else begin
			seq_a_start <= (seq_state == irq_flag_pkg::seq_idle) &&
				(next_seq_state == irq_flag_pkg::seq_run_a);
			seq_b_start <= (seq_state == irq_flag_pkg::seq_idle) &&
				(next_seq_state == irq_flag_pkg::seq_run_b);
		end
	end

	assign seq_a_busy = (seq_state == irq_flag_pkg::seq_run_a);
	assign seq_b_busy = (seq_state == irq_flag_pkg::seq_run_b);

	assign break_attempt = seq_a_busy && seq_b_req;
	assign end_of_sequence = (seq_a_busy || seq_b_busy) && seq_done;

	// ****************************************
	// event vector
	// ****************************************
	always_comb begin
		events = irq_flag_pkg::ALL_ZEROS;
		events[irq_flag_pkg::BIT_BREAK] = break_attempt;
		events[irq_flag_pkg::BIT_OUTLIER] = outlier_event;
		events[irq_flag_pkg::BIT_FIFO_UNDERFLOW] = fifo_underflow_event;
		events[irq_flag_pkg::BIT_FIFO_OVERFLOW] = fifo_overflow_event;
		events[irq_flag_pkg::BIT_FIFO_THRESHOLD] = fifo_threshold_event;
		events[irq_flag_pkg::BIT_FIFO_EMPTY] = fifo_empty_event;
		events[irq_flag_pkg::BIT_FIFO_FULL] = fifo_full_event;
		events[irq_flag_pkg::BIT_SEQ_TIMEOUT_ERROR] = seq_timeout_error_event;
		events[irq_flag_pkg::BIT_SEQ_TIMEOUT_DONE] = seq_timeout_done_event;
		events[irq_flag_pkg::BIT_END_OF_SEQUENCE] = end_of_sequence;
		events[irq_flag_pkg::BIT_BOOT_DONE] = boot_done_event;
	end

	// ****************************************
	// select registers
	// ****************************************
	// enables, boot done at reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_enable_0 <= irq_flag_pkg::RST_SELECT;
		end else if (req.wr &&
			irq_flag_pkg::addr_hit(req.waddr, irq_flag_pkg::OFF_SELECT_0)) begin
			irq_enable_0 <= (irq_enable_0 & ~wmask) | (req.wdata & wmask);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_enable_1 <= irq_flag_pkg::RST_SELECT;
		end else if (req.wr &&
			irq_flag_pkg::addr_hit(req.waddr, irq_flag_pkg::OFF_SELECT_1)) begin
			irq_enable_1 <= (irq_enable_1 & ~wmask) | (req.wdata & wmask);
		end
	end

	// ****************************************
	// clear strobe and flag registers
	// ****************************************
	// write one clears flag
	assign irq_clear_bit = (req.wr &&
		irq_flag_pkg::addr_hit(req.waddr, irq_flag_pkg::OFF_CLEAR)) ?
		(req.wdata & wmask) : irq_flag_pkg::ALL_ZEROS;

	sticky_bank u_flags_0 (
		.clk_sys(clk_sys),
		.rst(rst),
		.set(events & irq_enable_0 & irq_flag_pkg::IMPL_MASK),
		.clr(irq_clear_bit),
		.q(interrupt_flags_0)
	);

	sticky_bank u_flags_1 (
		.clk_sys(clk_sys),
		.rst(rst),
		.set(events & irq_enable_1 & irq_flag_pkg::IMPL_MASK),
		.clr(irq_clear_bit),
		.q(interrupt_flags_1)
	);

	// ****************************************
	// summary status, mask and interrupt line
	// ****************************************
	assign status_clear = (req.rd &&
		irq_flag_pkg::addr_hit(req.raddr, irq_flag_pkg::OFF_EVENT_STATUS)) ?
		irq_flag_pkg::ALL_ONES : irq_flag_pkg::ALL_ZEROS;

	sticky_bank u_event_status (
		.clk_sys(clk_sys),
		.rst(rst),
		.set(events & irq_flag_pkg::IMPL_MASK),
		.clr(status_clear),
		.q(event_status)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			event_mask <= irq_flag_pkg::RST_EVENT_MASK;
		end else if (req.wr &&
			irq_flag_pkg::addr_hit(req.waddr, irq_flag_pkg::OFF_EVENT_MASK)) begin
			event_mask <= (event_mask & ~wmask) | (req.wdata & wmask);
		end
	end

	assign irq = |(event_status & event_mask & irq_flag_pkg::IMPL_MASK);

	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		rd_data = irq_flag_pkg::ALL_ZEROS;
		if (irq_flag_pkg::addr_hit(req.raddr, irq_flag_pkg::OFF_FLAGS_0)) begin
			rd_data = interrupt_flags_0 & irq_flag_pkg::IMPL_MASK;
		end else if (irq_flag_pkg::addr_hit(req.raddr,
			irq_flag_pkg::OFF_FLAGS_1)) begin
			rd_data = interrupt_flags_1 & irq_flag_pkg::IMPL_MASK;
		end else if (irq_flag_pkg::addr_hit(req.raddr,
			irq_flag_pkg::OFF_SELECT_0)) begin
			rd_data = irq_enable_0;
		end else if (irq_flag_pkg::addr_hit(req.raddr,
			irq_flag_pkg::OFF_SELECT_1)) begin
			rd_data = irq_enable_1;
		end else if (irq_flag_pkg::addr_hit(req.raddr,
			irq_flag_pkg::OFF_EVENT_STATUS)) begin
			rd_data = event_status;
		end else if (irq_flag_pkg::addr_hit(req.raddr,
			irq_flag_pkg::OFF_EVENT_MASK)) begin
			rd_data = event_mask;
		end
	end

endmodule : interrupt_flag_status

`default_nettype wire

/* bench/irq_flag_assertions.sv */
// Purpose: port-level checks of the interrupt flag block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every interrupt_flag_status instance
`timescale 1ns/1ps
`default_nettype none
module irq_flag_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic seq_a_req,
	input wire logic seq_b_req,
	input wire logic seq_done,
	input wire logic seq_a_start,
	input wire logic seq_b_start,
	input wire logic seq_a_busy,
	input wire logic seq_b_busy,
	input wire logic irq
);
	// ****************************************
	// sequencer arbitration
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_a_grant: assert property (
		!seq_a_busy && !seq_b_busy && seq_a_req |=> seq_a_busy && seq_a_start)
		else $error("idle request a not granted");
	a_b_grant: assert property (
		!seq_a_busy && !seq_b_busy && !seq_a_req && seq_b_req
		|=> seq_b_busy && seq_b_start)
		else $error("idle request b not granted");
	a_b_dropped: assert property (
		seq_a_busy && seq_b_req |=> !seq_b_busy && !seq_b_start)
		else $error("request b not dropped during a");
	a_one_busy: assert property (!(seq_a_busy && seq_b_busy))
		else $error("both sequences busy");
	a_busy_holds: assert property (
		seq_a_busy && !seq_done |=> seq_a_busy)
		else $error("sequence a ended without done");
	a_done_idle: assert property (
		seq_done && (seq_a_busy || seq_b_busy) |=> !seq_a_busy && !seq_b_busy)
		else $error("done did not return to idle");
	a_start_pulse: assert property (
		$rose(seq_a_busy) |-> seq_a_start ##1 !seq_a_start)
		else $error("start pulse wrong");
	// ****************************************
	// register port
	// ****************************************
	a_read_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	a_reset_clear: assert property (disable iff (1'b0)
		rst |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !seq_a_busy)
		else $error("outputs not cleared by reset");
	c_break: cover property (seq_a_busy && seq_b_req);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
	c_irq: cover property ($rose(irq));
endmodule : irq_flag_assertions
bind interrupt_flag_status irq_flag_assertions chk_u (.clk_sys(clk_sys),
	.rst(rst), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .seq_a_req(seq_a_req), .seq_b_req(seq_b_req),
	.seq_done(seq_done), .seq_a_start(seq_a_start), .seq_b_start(seq_b_start),
	.seq_a_busy(seq_a_busy), .seq_b_busy(seq_b_busy), .irq(irq));
`default_nettype wire

/* bench/interrupt_flag_status_test.sv */
// Purpose: register-level tests of the interrupt flag block
// Assumes: AXI4-Lite master tasks, events pulsed one cycle
// Notes: expectations built from package bit positions
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_status_test;
	logic clk_sys = 0, rst = 1;
	logic [15:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, d, ex;
	logic [1:0] r;
	logic a_req = 0, b_req = 0, done = 0;
	logic a_start, b_start, a_busy, b_busy, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [8:0] ev = 0;
	logic [3:0] wstrb = 4'hf;
	int error_cnt = 0, n_compared = 0, cyc = 0;
	int unsigned bits [9] = '{irq_flag_pkg::BIT_OUTLIER,
		irq_flag_pkg::BIT_FIFO_UNDERFLOW, irq_flag_pkg::BIT_FIFO_OVERFLOW,
		irq_flag_pkg::BIT_FIFO_THRESHOLD, irq_flag_pkg::BIT_FIFO_EMPTY,
		irq_flag_pkg::BIT_FIFO_FULL, irq_flag_pkg::BIT_SEQ_TIMEOUT_ERROR,
		irq_flag_pkg::BIT_SEQ_TIMEOUT_DONE, irq_flag_pkg::BIT_BOOT_DONE};
	interrupt_flag_status dut_u (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .seq_a_req(a_req),
		.seq_b_req(b_req), .seq_done(done), .seq_a_start(a_start),
		.seq_b_start(b_start), .seq_a_busy(a_busy), .seq_b_busy(b_busy),
		.outlier_event(ev[0]), .fifo_underflow_event(ev[1]),
		.fifo_overflow_event(ev[2]), .fifo_threshold_event(ev[3]),
		.fifo_empty_event(ev[4]), .fifo_full_event(ev[5]),
		.seq_timeout_error_event(ev[6]), .seq_timeout_done_event(ev[7]),
		.boot_done_event(ev[8]), .irq(irq));
	// ****************************************
	// clock, timeout and shared tasks
	// ****************************************
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge clk_sys);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge clk_sys);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 0;
		@(posedge clk_sys);
	endtask : rd
	task automatic pulse(input logic [8:0] m);
		ev <= m;
		@(posedge clk_sys);
		ev <= 0;
	endtask : pulse
	task automatic seq(input logic [2:0] m);
		{done, b_req, a_req} <= m;
		@(posedge clk_sys);
		{done, b_req, a_req} <= 3'h0;
		@(posedge clk_sys);
	endtask : seq
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		rd(16'h3010); chk("flags0 reset", d, 32'h0);
		rd(16'h3014); chk("flags1 reset", d, 32'h0);
		rd(16'h3008); chk("select0 reset", d, 32'h00002000);
		rd(16'h3000); chk("unmapped resp", {30'h0, r}, 32'h2);
		wr(16'h3010, 32'hffffffff); chk("flag wr resp", {30'h0, r}, 32'h0);
		rd(16'h3010); chk("flag wr ignored", d, 32'h0);
		pulse(9'h100);
		rd(16'h3014); chk("boot flags1", d, 32'h00002000);
		wr(16'h3004, 32'h00002000);
		rd(16'h3014); chk("boot cleared", d, 32'h0);
		$display("test reset done");
		wr(16'h3008, 32'hffffffff);
		wstrb <= 4'h2;
		wr(16'h300c, 32'hffffffff);
		wstrb <= 4'hf;
		rd(16'h300c); chk("select1 lane", d, 32'h0000ff00);
		wr(16'h300c, 32'h0);
		ex = 0;
		for (int i = 0; i < 9; i++) begin
			pulse(9'h1 << i);
			ex = ex | (32'h1 << bits[i]);
			rd(16'h3010); chk("flag set", d, 32'h1 << bits[i]);
			rd(16'h3010); chk("flag kept", d, 32'h1 << bits[i]);
			rd(16'h3014); chk("flags1 gated", d, 32'h0);
			wr(16'h3004, 32'h1 << bits[i]);
			rd(16'h3010); chk("flag cleared", d, 32'h0);
		end
		pulse(9'h1ff);
		rd(16'h3010); chk("all flags", d, ex);
		wr(16'h3004, 32'hffffffff);
		$display("test flags done");
		seq(3'h1); chk("a busy", {30'h0, a_busy, a_start}, 32'h3);
		seq(3'h2); chk("b dropped", {30'h0, a_busy, b_busy}, 32'h2);
		seq(3'h4); chk("a idle", {31'h0, a_busy}, 32'h0);
		rd(16'h3010); chk("break eos", d, 32'h80008000);
		wr(16'h3004, 32'hffffffff);
		seq(3'h2); chk("b busy", {30'h0, b_busy, b_start}, 32'h3);
		seq(3'h4);
		$display("test sequencer done");
		rd(16'h3018);
		wr(16'h301c, 32'h00002000);
		pulse(9'h100);
		@(posedge clk_sys);
		chk("irq on", {31'h0, irq}, 32'h1);
		pulse(9'h001);
		rd(16'h3018); chk("status", d, 32'h20002000);
		@(posedge clk_sys);
		chk("irq off", {31'h0, irq}, 32'h0);
		pulse(9'h001);
		@(posedge clk_sys);
		chk("irq masked", {31'h0, irq}, 32'h0);
		$display("test interrupt done");
		summarize();
	end
endmodule : interrupt_flag_status_test
`default_nettype wire
